// [src/sstb_pkg.sv]
package sstb_pkg;
   // Register offsets on the plain register port.
   localparam logic [1:0]  OFS_TRANSMIT_DATA_BUFFER   = 2'h0;
   localparam logic [1:0]  OFS_TRANSMIT_CONTROL_STATUS    = 2'h1;
   localparam logic [1:0]  OFS_RECEIVE_CONTROL_STATUS    = 2'h2;
   localparam logic [1:0]  OFS_PARAMETER_CONTROL_REGISTER   = 2'h3;
   // Transmit data buffer fields.
   localparam int          BUF_SOM      = 8;
   localparam int          BUF_EOM      = 9;
   localparam int          BUF_ABORT    = 10;
   // Transmit control and status fields.
   localparam int          CSR_MCLK     = 2;
   localparam int          CSR_MAINT    = 3;
   localparam int          CSR_SEND     = 4;
   localparam int          CSR_EMPTY    = 7;
   localparam int          CSR_DEVRST   = 8;
   localparam int          CSR_ACTIVE   = 9;
   localparam int          CSR_URUN     = 15;
   // Receive status (modem) fields.
   localparam int          MDM_LINES    = 4;
   localparam int          MDM_CTL_LSB  = 4;
   localparam int          MDM_CHG      = 15;
   // Parameter register fields.
   localparam int          PAR_NOCRC    = 9;
   localparam int          PAR_CPS      = 15;
   // Reset values.
   localparam logic [7:0]  RST_CHAR     = 8'h00;
   localparam logic [15:0] RST_WORD     = 16'h0000;
   // Line characters, CRC polynomials, stuffing run length and last bit index.
   localparam logic [7:0]  FLAG_CHAR    = 8'h7E;
   localparam logic [7:0]  ABORT_CHAR   = 8'hFF;
   localparam logic [15:0] POLY_BIT     = 16'h1021;
   localparam logic [15:0] POLY_CHAR    = 16'h8005;
   localparam logic [2:0]  STUFF_ONES   = 3'h5;
   localparam logic [2:0]  LAST_BIT     = 3'h7;
   // Timing: bit clock ceiling and the lead-in before the first bit.
   localparam int          CORE_HZ      = 50000000;
   localparam int          BIT_MAX_HZ   = 10000;
   localparam int          CYC_PER_BIT  = CORE_HZ / BIT_MAX_HZ;
   localparam logic [1:0]  LEAD_BITS    = 2'h2;

   typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_SHIFT} sstb_state_t;
   typedef enum logic [2:0] {K_FLAG, K_SYNC, K_DATA, K_CRC_HI, K_CRC_LO, K_ABORT} sstb_kind_t;
endpackage

// [src/sstb_sync.sv]
`timescale 1ns/1ps
module sstb_sync #(
   parameter int W = 1
) (
   input  wire logic         core_clk_i,
   input  wire logic         rst_n_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_r;

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         meta_r <= '0;
         q_o    <= '0;
      end else begin
         meta_r <= d_i;
         q_o    <= meta_r;
      end
   end
endmodule

// [src/sstb_crc.sv]
`timescale 1ns/1ps
module sstb_crc (
   input  wire logic        core_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        init_i,
   input  wire logic        ones_i,
   input  wire logic        en_i,
   input  wire logic        bit_i,
   input  wire logic [15:0] poly_i,
   output logic      [15:0] crc_o
);
   wire        fb_w  = crc_o[15] ^ bit_i;
   wire [15:0] nxt_w = {crc_o[14:0], 1'b0} ^ (fb_w ? poly_i : 16'h0000);

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         crc_o <= 16'h0000;
      end else if (init_i) begin
         crc_o <= ones_i ? 16'hFFFF : 16'h0000;
      end else if (en_i) begin
         crc_o <= nxt_w;
      end
   end
endmodule

// [src/sstb_top.sv]
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps
module sstb_top (
   input  wire logic        core_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic [1:0]  reg_addr_i,
   input  wire logic [15:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [15:0] reg_rdata_o,
   input  wire logic        tx_bit_clk_i,
   input  wire logic [3:0]  modem_stat_i,
   output logic      [1:0]  modem_ctl_o,
   output logic             tx_data_o
);
   sstb_pkg::sstb_state_t state_r;
   sstb_pkg::sstb_kind_t  kind_r;
   sstb_pkg::sstb_kind_t  sel_kind;
   logic [7:0]  buf_r;
   logic        som_r, eom_r, abort_r;
   logic        send_r, maint_r, mclk_r, mclk_prev_r;
   logic        cps_r, nocrc_r;
   logic        empty_r, urun_r, chg_r;
   logic [1:0]  mctl_r;
   logic [7:0]  sr_r;
   logic [2:0]  cnt_r;
   logic [2:0]  ones_r;
   logic [1:0]  lead_r;
   logic        clk_s, clk_prev_r;
   logic [3:0]  mdm_s, mdm_prev_r;
   logic [15:0] crc_w;
   logic [7:0]  sel_char;
   logic        sel_urun;

   // Program device reset clears what the bus reset clears, except the synchronisers, edge and change detectors, CRC and read data.
   wire dev_rst  = reg_wr_i && reg_addr_i == sstb_pkg::OFS_TRANSMIT_CONTROL_STATUS
                   && reg_wdata_i[sstb_pkg::CSR_DEVRST];
   wire clr      = !rst_n_i || dev_rst;
   wire wr_buf   = reg_wr_i && reg_addr_i == sstb_pkg::OFS_TRANSMIT_DATA_BUFFER;
   wire wr_csr   = reg_wr_i && reg_addr_i == sstb_pkg::OFS_TRANSMIT_CONTROL_STATUS && !dev_rst;
   wire wr_mdm   = reg_wr_i && reg_addr_i == sstb_pkg::OFS_RECEIVE_CONTROL_STATUS;
   wire wr_par   = reg_wr_i && reg_addr_i == sstb_pkg::OFS_PARAMETER_CONTROL_REGISTER;
   wire rd_mdm   = reg_rd_i && reg_addr_i == sstb_pkg::OFS_RECEIVE_CONTROL_STATUS;
   wire som_wr   = wr_buf && reg_wdata_i[sstb_pkg::BUF_SOM];

   // The modem bit clock is sampled, never used as a clock, so only its edges matter.
   sstb_sync #(
      .W (1)
   ) u_clk_sync (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .d_i        (tx_bit_clk_i),
      .q_o        (clk_s)
   );

   sstb_sync #(
      .W (4)
   ) u_mdm_sync (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .d_i        (modem_stat_i),
      .q_o        (mdm_s)
   );

   // Maintenance mode steps the transmitter on rising software clock edges.
   wire tick     = maint_r ? (mclk_r && !mclk_prev_r) : (clk_s && !clk_prev_r);
   wire shifting = state_r == sstb_sup_shift();
   wire stuffable = !cps_r && (kind_r == sstb_pkg::K_DATA || kind_r == sstb_pkg::K_CRC_HI
                    || kind_r == sstb_pkg::K_CRC_LO);
   // Five ones carried over from the last data bit still force a zero ahead of a flag.
   wire stuff_now = !cps_r && ones_r == sstb_pkg::STUFF_ONES;
   wire shift_bit = shifting && tick && !stuff_now;
   wire boundary  = shift_bit && cnt_r == sstb_pkg::LAST_BIT;
   wire lead_done = state_r == sstb_pkg::ST_LEAD && tick && lead_r == sstb_pkg::LEAD_BITS - 2'h1;
   wire load_chr  = (boundary && send_r) || (lead_done && send_r);
   // At a data boundary the register has not yet taken the last bit, so it is folded in here.
   wire [15:0] poly_w   = cps_r ? sstb_pkg::POLY_CHAR : sstb_pkg::POLY_BIT;
   wire [15:0] crc_last = {crc_w[14:0], 1'b0} ^ ((crc_w[15] ^ sr_r[0]) ? poly_w : 16'h0000);
   wire [15:0] crc_now  = (kind_r == sstb_pkg::K_DATA) ? crc_last : crc_w;
   wire [15:0] crc_tx   = cps_r ? crc_now : ~crc_now;
   wire [7:0]  crc_hi = {<<{crc_tx[15:8]}};
   wire [7:0]  crc_lo = {<<{crc_tx[7:0]}};
   wire [7:0]  fill   = cps_r ? buf_r : sstb_pkg::FLAG_CHAR;
   wire        urun_set  = load_chr && sel_urun;
   wire        empty_set = load_chr || (boundary && !send_r);

   function automatic sstb_pkg::sstb_state_t sstb_sup_shift();
      return sstb_pkg::ST_SHIFT;
   endfunction

   // Choice of the next character at a character boundary.
   always_comb begin
      sel_kind = sstb_pkg::K_DATA;
      sel_char = buf_r;
      sel_urun = 1'b0;
      if (kind_r == sstb_pkg::K_CRC_HI && shifting) begin
         sel_kind = sstb_pkg::K_CRC_LO;
         sel_char = crc_lo;
      end else if (som_r) begin
         sel_kind = cps_r ? sstb_pkg::K_SYNC : sstb_pkg::K_FLAG;
         sel_char = fill;
      end else if (abort_r) begin
         sel_kind = sstb_pkg::K_ABORT;
         sel_char = sstb_pkg::ABORT_CHAR;
      end else if (eom_r) begin
         if (kind_r == sstb_pkg::K_DATA && !nocrc_r) begin
            sel_kind = sstb_pkg::K_CRC_HI;
            sel_char = crc_hi;
         end else begin
            sel_kind = sstb_pkg::K_FLAG;
            sel_char = sstb_pkg::FLAG_CHAR;
         end
      end else if (!empty_r) begin
         sel_kind = sstb_pkg::K_DATA;
         sel_char = buf_r;
      end else begin
         sel_kind = cps_r ? sstb_pkg::K_SYNC : sstb_pkg::K_FLAG;
         sel_char = fill;
         sel_urun = kind_r == sstb_pkg::K_DATA;
      end
   end

   // CRC runs only on data bits, never on inserted zeros, flags or sync.
   sstb_crc u_crc (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .init_i     (som_wr),
      .ones_i     (!cps_r),
      .en_i       (shift_bit && kind_r == sstb_pkg::K_DATA),
      .bit_i      (sr_r[0]),
      .poly_i     (cps_r ? sstb_pkg::POLY_CHAR : sstb_pkg::POLY_BIT),
      .crc_o      (crc_w)
   );

   always_ff @(posedge core_clk_i) begin
      if (clr) begin
         buf_r   <= sstb_pkg::RST_CHAR;
         som_r   <= 1'b0;
         eom_r   <= 1'b0;
         abort_r <= 1'b0;
      end else if (wr_buf) begin
         buf_r   <= reg_wdata_i[7:0];
         som_r   <= reg_wdata_i[sstb_pkg::BUF_SOM];
         eom_r   <= reg_wdata_i[sstb_pkg::BUF_EOM];
         abort_r <= reg_wdata_i[sstb_pkg::BUF_ABORT];
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (clr) begin
         send_r  <= 1'b0;
         maint_r <= 1'b0;
         mclk_r  <= 1'b0;
         cps_r   <= 1'b0;
         nocrc_r <= 1'b0;
         mctl_r  <= 2'h0;
      end else begin
         if (wr_csr) begin
            send_r  <= reg_wdata_i[sstb_pkg::CSR_SEND];
            maint_r <= reg_wdata_i[sstb_pkg::CSR_MAINT];
            mclk_r  <= reg_wdata_i[sstb_pkg::CSR_MCLK];
         end
         if (wr_par) begin
            cps_r   <= reg_wdata_i[sstb_pkg::PAR_CPS];
            nocrc_r <= reg_wdata_i[sstb_pkg::PAR_NOCRC];
         end
         if (wr_mdm) begin
            mctl_r  <= reg_wdata_i[sstb_pkg::MDM_CTL_LSB +: 2];
         end
      end
   end

   // Flags: hardware set wins over the software clear in the same cycle.
   always_ff @(posedge core_clk_i) begin
      if (clr) begin
         empty_r <= 1'b1;
         urun_r  <= 1'b0;
      end else begin
         empty_r <= empty_set || (empty_r && !wr_buf);
         urun_r  <= urun_set || (urun_r && !som_wr);
      end
   end

   // Modem lines are reported only; nothing here gates the transmitter on them.
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         mdm_prev_r  <= 4'h0;
         chg_r       <= 1'b0;
         clk_prev_r  <= 1'b0;
         mclk_prev_r <= 1'b0;
      end else begin
         mdm_prev_r  <= mdm_s;
         chg_r       <= (mdm_s != mdm_prev_r) || (chg_r && !rd_mdm);
         clk_prev_r  <= clk_s;
         mclk_prev_r <= mclk_r;
      end
   end

   // Transmit sequencer.
   always_ff @(posedge core_clk_i) begin
      if (clr) begin
         state_r   <= sstb_pkg::ST_IDLE;
         kind_r    <= sstb_pkg::K_FLAG;
         sr_r      <= 8'hFF;
         cnt_r     <= 3'h0;
         ones_r    <= 3'h0;
         lead_r    <= 2'h0;
         tx_data_o <= 1'b1;
      end else begin
         case (state_r)
            sstb_pkg::ST_IDLE: begin
               lead_r <= 2'h0;
               ones_r <= 3'h0;
               if (send_r && som_r) begin
                  state_r <= sstb_pkg::ST_LEAD;
               end
            end
            sstb_pkg::ST_LEAD: begin
               if (!send_r) begin
                  state_r <= sstb_pkg::ST_IDLE;
               end else if (lead_done) begin
                  state_r <= sstb_pkg::ST_SHIFT;
               end else if (tick) begin
                  lead_r <= lead_r + 2'h1;
               end
            end
            default: begin
               if (tick && stuff_now) begin
                  tx_data_o <= 1'b0;
                  ones_r    <= 3'h0;
               end else if (shift_bit) begin
                  tx_data_o <= sr_r[0];
                  sr_r      <= {1'b1, sr_r[7:1]};
                  cnt_r     <= cnt_r + 3'h1;
                  ones_r    <= (sr_r[0] && stuffable) ? ones_r + 3'h1 : 3'h0;
                  if (boundary && !send_r) begin
                     state_r <= sstb_pkg::ST_IDLE;
                  end
               end
            end
         endcase
         if (load_chr) begin
            kind_r <= sel_kind;
            sr_r   <= sel_char;
            cnt_r  <= 3'h0;
         end
         // The last bit of a frame keeps its full bit time before the line returns to mark.
         if (state_r != sstb_pkg::ST_SHIFT && tick) begin
            tx_data_o <= 1'b1;
         end
      end
   end

   // Register read port: data stand only in the cycle after the read strobe.
   wire [15:0] rd_buf = {5'h00, abort_r, eom_r, som_r, buf_r};
   wire [15:0] rd_csr = {urun_r, 5'h00, shifting, 1'b0, empty_r, 2'h0,
                         send_r, maint_r, mclk_r, 2'h0};
   wire [15:0] rd_mdmw = {chg_r, 9'h000, mctl_r, mdm_s};
   wire [15:0] rd_par = {cps_r, 5'h00, nocrc_r, 9'h000};
   wire [15:0] rd_mux = (reg_addr_i == sstb_pkg::OFS_TRANSMIT_DATA_BUFFER) ? rd_buf :
                        (reg_addr_i == sstb_pkg::OFS_TRANSMIT_CONTROL_STATUS)  ? rd_csr :
                        (reg_addr_i == sstb_pkg::OFS_RECEIVE_CONTROL_STATUS)  ? rd_mdmw : rd_par;

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= sstb_pkg::RST_WORD;
      end else begin
         reg_rdata_o <= reg_rd_i ? rd_mux : sstb_pkg::RST_WORD;
      end
   end

   assign modem_ctl_o = mctl_r;

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   a_som_clears_urun: assert property (som_wr && !dev_rst && !urun_set |=> !urun_r)
      else $error("start write left underrun set");
   a_load_clears_empty: assert property (wr_buf && !dev_rst && !empty_set |=> !empty_r)
      else $error("buffer load left empty flag set");
   a_empty_after_rst: assert property ($rose(rst_n_i) |-> empty_r)
      else $error("empty flag clear after reset");
   a_flag_sets_empty: assert property (boundary && send_r && som_r && !dev_rst
      |=> empty_r [*1] ##0 shifting)
      else $error("flag end did not set empty");
   a_enable_stops: assert property (boundary && !send_r |=> state_r == sstb_pkg::ST_IDLE)
      else $error("transmitter ran without enable");
   a_active_read: assert property (reg_rd_i && reg_addr_i == sstb_pkg::OFS_TRANSMIT_CONTROL_STATUS
      |=> reg_rdata_o[sstb_pkg::CSR_ACTIVE] == $past(shifting))
      else $error("active flag does not match state");
   a_stuff_zero: assert property (shifting && tick && stuff_now && !dev_rst |=> !tx_data_o)
      else $error("zero not inserted after five ones");
   a_lead_first: assert property (lead_done && send_r && !dev_rst |=> shifting)
      else $error("first character late after lead");
   a_urun_sets: assert property (urun_set && !dev_rst |=> urun_r)
      else $error("underrun not flagged");
   a_modem_change: assert property (mdm_s != mdm_prev_r && !dev_rst |=> chg_r)
      else $error("modem change not flagged");

   c_frame_start: cover property (state_r == sstb_pkg::ST_LEAD ##[1:100] shifting);
   c_crc_sent: cover property (load_chr && sel_kind == sstb_pkg::K_CRC_HI);
   c_underrun: cover property (urun_set);
endmodule

// [sim/sstb_modem.sv]
`timescale 1ns/1ps
module sstb_modem (
   input  wire logic run_i,
   input  wire logic tx_data_i,
   output logic      bit_clk_o
);
   // Line samples, oldest first; the bench inspects them.
   logic q[$];

   // The clock stands still outside frames, and its odd idle step keeps its phase
   // apart from the core clock.
   initial begin
      bit_clk_o = 1'b0;
      forever begin
         if (run_i === 1'b1) begin
            #80 bit_clk_o = 1'b1;
            q.push_back(tx_data_i);
            #80 bit_clk_o = 1'b0;
         end else begin
            #7;
         end
      end
   end
endmodule

// [sim/tb_sync_serial_transmit_buffer.sv]
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fails++; $display("wrong value t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_sync_serial_transmit_buffer;
   logic        core_clk_i;
   logic        rst_n_i;
   logic [1:0]  reg_addr_i;
   logic [15:0] reg_wdata_i;
   logic        reg_wr_i;
   logic        reg_rd_i;
   logic [15:0] reg_rdata_o;
   logic        tx_bit_clk_i;
   logic [3:0]  modem_stat_i;
   logic [1:0]  modem_ctl_o;
   logic        tx_data_o;
   logic        run;
   logic [15:0] rd;
   int          fails;
   int          n_tests;
   localparam logic [15:0] EMPTY  = 16'h1 << sstb_pkg::CSR_EMPTY;
   localparam logic [15:0] ACTIVE = 16'h1 << sstb_pkg::CSR_ACTIVE;
   localparam logic [15:0] URUN   = 16'h1 << sstb_pkg::CSR_URUN;
   localparam logic [15:0] SEND   = 16'h1 << sstb_pkg::CSR_SEND;
   localparam logic [15:0] SOM    = 16'h1 << sstb_pkg::BUF_SOM;
   localparam logic [15:0] EOM    = 16'h1 << sstb_pkg::BUF_EOM;
   localparam logic [15:0] MAINT  = 16'h1 << sstb_pkg::CSR_MAINT;
   localparam logic [15:0] MCLK   = 16'h1 << sstb_pkg::CSR_MCLK;

   sstb_top uut (
      .core_clk_i   (core_clk_i),
      .rst_n_i      (rst_n_i),
      .reg_addr_i   (reg_addr_i),
      .reg_wdata_i  (reg_wdata_i),
      .reg_wr_i     (reg_wr_i),
      .reg_rd_i     (reg_rd_i),
      .reg_rdata_o  (reg_rdata_o),
      .tx_bit_clk_i (tx_bit_clk_i),
      .modem_stat_i (modem_stat_i),
      .modem_ctl_o  (modem_ctl_o),
      .tx_data_o    (tx_data_o)
   );

   sstb_modem modem (
      .run_i     (run),
      .tx_data_i (tx_data_o),
      .bit_clk_o (tx_bit_clk_i)
   );

   initial begin
      core_clk_i = 1'b0;
      forever #10 core_clk_i = ~core_clk_i;
   end

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Each access leaves an idle cycle so no strobe is driven twice in one step.
   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge core_clk_i);
      reg_wr_i    <= 1'b0;
      @(posedge core_clk_i);
   endtask

   task automatic rdr(input logic [1:0] a);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge core_clk_i);
      reg_rd_i   <= 1'b0;
      #1 rd = reg_rdata_o;
      @(posedge core_clk_i);
   endtask

   task automatic bits(input int n);
      int s;
      int k;
      s = modem.q.size();
      for (k = 0; k < n * 12 && modem.q.size() < s + n; k++) begin
         @(posedge core_clk_i);
      end
      if (modem.q.size() < s + n) begin
         fails++;
         conclude();
      end
   endtask

   // Looks for the first n bits of p, bit 0 first, anywhere on the line.
   function automatic logic has(input logic [31:0] p, input int n);
      for (int i = 0; i + n <= modem.q.size(); i++) begin
         int k;
         for (k = 0; k < n; k++) begin
            if (modem.q[i + k] !== p[k]) break;
         end
         if (k == n) return 1'b1;
      end
      return 1'b0;
   endfunction

   task automatic endt(input string name);
      $display("test %s done", name);
   endtask

   initial begin
      fails = 0;
      n_tests = 0;
      run = 1'b0;
      rst_n_i = 1'b0;
      reg_addr_i = 2'h0;
      reg_wdata_i = 16'h0000;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      modem_stat_i = 4'h0;
      repeat (4) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      @(posedge core_clk_i);

      rdr(2'h1); `CHK(rd, EMPTY)
      rdr(2'h0); `CHK(rd, 16'h0000)
      wr(2'h0, 16'h01A5);
      rdr(2'h0); `CHK(rd, 16'h01A5)
      rdr(2'h1); `CHK(rd, 16'h0000)
      wr(2'h1, 16'h1 << sstb_pkg::CSR_DEVRST);
      rdr(2'h0); `CHK(rd, 16'h0000)
      rdr(2'h1); `CHK(rd, EMPTY)
      endt("registers");

      modem_stat_i <= 4'h9;
      repeat (4) @(posedge core_clk_i);
      rdr(2'h2); `CHK(rd, 16'h8009)
      rdr(2'h2); `CHK(rd, 16'h0009)
      wr(2'h2, 16'h0030);
      `CHK(modem_ctl_o, 2'h3)
      rdr(2'h2); `CHK(rd, 16'h0039)
      endt("modem");

      // The status lines stay at a non-ready pattern: frames must still flow.
      modem_stat_i <= 4'h0;
      wr(2'h1, SEND);
      modem.q.delete();
      run <= 1'b1;
      wr(2'h0, SOM);
      bits(4);
      `CHK(has(32'h0, 1), 1'b1)
      bits(20);
      `CHK(has(32'h7E7E, 16), 1'b1)
      rdr(2'h1); `CHK(rd & (ACTIVE | EMPTY), ACTIVE | EMPTY)
      wr(2'h0, 16'h003C);
      bits(30);
      `CHK(has({8'h3C, 8'h7E}, 16), 1'b1)
      rdr(2'h1); `CHK(rd & URUN, URUN)
      endt("flags and data");

      wr(2'h1, 16'h0000);
      bits(20);
      for (int k = 0; k < 8; k++) begin
         `CHK(modem.q[modem.q.size() - 1 - k], 1'b1)
      end
      rdr(2'h1); `CHK(rd & (ACTIVE | URUN), URUN)
      run <= 1'b0;
      wr(2'h1, SEND);
      modem.q.delete();
      run <= 1'b1;
      wr(2'h0, SOM);
      rdr(2'h1); `CHK(rd & URUN, 16'h0000)
      bits(12);
      wr(2'h0, 16'h00FF);
      bits(30);
      `CHK(has({9'h1DF, 8'h7E}, 17), 1'b1)
      endt("underrun and stuffing");

      wr(2'h1, 16'h1 << sstb_pkg::CSR_DEVRST);
      run <= 1'b0;
      wr(2'h3, 16'h1 << sstb_pkg::PAR_CPS);
      wr(2'h1, SEND);
      modem.q.delete();
      run <= 1'b1;
      wr(2'h0, SOM | 16'h0016);
      bits(30);
      `CHK(has({8'h16, 8'h16}, 16), 1'b1)
      wr(2'h1, 16'h0000);
      bits(20);
      run <= 1'b0;
      endt("character mode");

      // One zero byte, then the end bit: CRC high, CRC low, closing flag.
      wr(2'h1, 16'h1 << sstb_pkg::CSR_DEVRST);
      wr(2'h1, SEND);
      modem.q.delete();
      run <= 1'b1;
      wr(2'h0, SOM);
      bits(12);
      wr(2'h0, 16'h0000);
      rd = 16'h0000;
      for (int k = 0; k < 200 && (rd & EMPTY) == 16'h0000; k++) begin
         rdr(2'h1);
      end
      if ((rd & EMPTY) == 16'h0000) begin
         fails++;
         conclude();
      end
      wr(2'h0, EOM);
      bits(50);
      `CHK(has(32'h7EF07800, 32), 1'b1)
      rdr(2'h1); `CHK(rd & URUN, 16'h0000)
      wr(2'h1, 16'h0000);
      bits(20);
      run <= 1'b0;
      endt("end of message");

      wr(2'h1, 16'h1 << sstb_pkg::CSR_DEVRST);
      wr(2'h1, SEND | MAINT);
      wr(2'h0, SOM);
      for (int k = 0; k < 4; k++) begin
         wr(2'h1, SEND | MAINT | MCLK);
         wr(2'h1, SEND | MAINT);
         if (k == 2) `CHK(tx_data_o, 1'b0)
      end
      `CHK(tx_data_o, 1'b1)
      endt("maintenance clock");
      conclude();
   end
endmodule
